// ### lig_pkg.sv
// Shared constants for the LED intensity and stored-register readback block.
package lig_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the Avalon-MM slave)
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_IRQ_STATUS = 5'h00;
   localparam logic [4:0] REG_IRQ_CLEAR  = 5'h04;
   localparam logic [4:0] REG_IRQ_ENABLE = 5'h08;
   localparam logic [4:0] REG_STATE      = 5'h0c;
   localparam logic [4:0] REG_LEVELS     = 5'h10;
   localparam logic [4:0] REG_APP_CTRL   = 5'h14;

   // Interrupt bit positions.
   localparam int IRQ_RB_DONE  = 0;
   localparam int IRQ_NVM_WR   = 1;
   localparam int IRQ_CTRL     = 2;
   localparam int IRQ_LINK_ERR = 3;
   localparam int IRQ_W        = 4;

   // Application control bit positions.
   localparam int APP_TEMP_WARN = 0;
   localparam int APP_OVERTEMP  = 1;
   localparam int APP_PROG_ERR  = 2;
   localparam int APP_LOC_DEF   = 3;
   localparam int APP_W         = 4;

   // ----------------------------------------------------------------
   // Stored registers and response fields
   // ----------------------------------------------------------------
   localparam int         NVM_WORDS     = 17;
   localparam logic [5:0] NVM_ADDR_MAX  = 6'h10;
   localparam logic [5:0] NVM_ADDR_RST  = 6'h00;
   localparam int         COLOR_SETS    = 16;

   // Link status codes carried in bits 7:5 of the first response byte.
   localparam logic [2:0] LS_OK         = 3'h0;
   localparam logic [2:0] LS_RESET      = 3'h1;

   // Application info bits 3:2 codes.
   localparam logic [1:0] AI_OVERTEMP   = 2'h2;
   localparam logic [1:0] AI_PROG_ERR   = 2'h3;

   // ----------------------------------------------------------------
   // Intensity generation
   // ----------------------------------------------------------------
   // Global factors are in 1/128 steps: 2/128 is 1.56 %, 128/128 is 100 %.
   localparam logic [7:0] GSCALE [16] = '{
      8'h00, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0c, 8'h10,
      8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'h80, 8'h80};
   // One pulse period spans full level 0xff times full factor 0x80.
   localparam logic [14:0] PWM_PERIOD   = 15'h7f80;
   localparam logic [3:0]  GINT_RST     = 4'h0;
   localparam logic [3:0]  COLOR_RST    = 4'h0;

endpackage

// ### lig_pwm.sv
// One output channel: scales a level by the global factor and drives a pulse stream.
`timescale 1ns/1ps
`default_nettype none
module lig_pwm (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Shared period counter and settings
   input  wire logic [14:0] phase_i,
   input  wire logic [7:0]  level_i,
   input  wire logic [7:0]  gscale_i,
   // Pulse output
   output var  logic        pulse_o
);

   logic [15:0] total;
   logic        pulse_next;
   logic        pulse_reg;

   // Product of relative level and global factor, in units of one phase step.
   assign total      = level_i * gscale_i;
   // Duty is total over the period.
   assign pulse_next = ({1'b0, phase_i} < total);
   assign pulse_o    = pulse_reg;

   // Registered so the output pin never glitches on compare ripple.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= pulse_next;
      end
   end

endmodule
`default_nettype wire

// ### lig_core.sv
// Readback responder, color set storage and three-channel intensity generator.
//
// Notes on behaviour
// - Response carries an enhanced checksum.
// - One stored word per response, picked by a counter.
// - Reset clears the counter.
// - A stored write loads the counter with its address.
// - Byte one: status and info; byte two: address.
// - Bytes three to five carry bits 0-7, 8-15 and 16-23.
// - Output is level times global intensity.
// - Pulse duty equals total intensity.
// - Control frame sets the global code; reset zero.
// - Global code maps to a fixed factor table.
// - Sixteen color sets of three bytes are stored.
// - Color field picks the set; default zero.
// - Selection copies the set into the level registers.
// - Direct frame overwrites the levels.
// - Relative level is the register value over 0xff.
// - Link status codes: 0 ok, 1 reset, 4 data, 5 checksum, 6 framing, 7 parity.
// - Info bit 0 warning, bit 1 low, bits 3:2 fault code, bit 4 default id.
//
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module lig_core (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [3:0]  avs_byteenable_i,
   input  wire logic [31:0] avs_writedata_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o,
   // Master control frame
   input  wire logic        master_control_frame_i,
   input  wire logic [3:0]  ctrl_color_i,
   input  wire logic [3:0]  ctrl_gint_i,
   // Direct level frame
   input  wire logic        direct_level_frame_i,
   input  wire logic [7:0]  direct_ch1_i,
   input  wire logic [7:0]  direct_ch2_i,
   input  wire logic [7:0]  direct_ch3_i,
   // Stored-register write frame
   input  wire logic        nvm_write_frame_i,
   input  wire logic [5:0]  nvm_wr_addr_i,
   input  wire logic [23:0] nvm_wr_data_i,
   // Readback response to the protocol layer
   input  wire logic [7:0]  rb_pid_i,
   input  wire logic        rb_done_i,
   input  wire logic        rb_abort_i,
   input  wire logic        link_err_i,
   input  wire logic [2:0]  link_err_code_i,
   output var  logic [7:0]  rb_byte1_o,
   output var  logic [7:0]  rb_byte2_o,
   output var  logic [7:0]  stored_byte_low_o,
   output var  logic [7:0]  stored_byte_mid_o,
   output var  logic [7:0]  stored_byte_high_o,
   output var  logic [7:0]  rb_checksum_o,
   // LED outputs and interrupt
   output var  logic        led_output_a_o,
   output var  logic        led_output_b_o,
   output var  logic        led_output_c_o,
   output var  logic        irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } lig_bus_e;

   lig_bus_e     bus_reg;
   lig_bus_e     bus_next;
   logic [31:0]  rdata_reg;
   logic [31:0]  rdata_next;
   logic [lig_pkg::IRQ_W-1:0] irq_status_reg;
   logic [lig_pkg::IRQ_W-1:0] irq_enable_reg;
   logic [lig_pkg::APP_W-1:0] app_ctrl_reg;
   logic [23:0]  nvm_reg [lig_pkg::NVM_WORDS];
   logic [5:0]   rb_addr_reg;
   logic [5:0]   rb_addr_next;
   logic [2:0]   link_status_reg;
   logic [2:0]   link_status_next;
   logic [3:0]   gint_reg;
   logic [3:0]   color_reg;
   logic [7:0]   channel1_level_reg;
   logic [7:0]   channel2_level_reg;
   logic [7:0]   channel3_level_reg;
   logic [14:0]  phase_reg;
   logic [7:0]   byte1_reg;
   logic [7:0]   byte2_reg;
   logic [7:0]   lo_reg;
   logic [7:0]   mid_reg;
   logic [7:0]   hi_reg;
   logic [7:0]   chk_reg;

   localparam int IRQ_W_T = lig_pkg::IRQ_W;

   // ----------------------------------------------------------------
   // Avalon-MM slave: one wait state, then the answer
   // ----------------------------------------------------------------
   wire        bus_req   = avs_read_i | avs_write_i;
   wire        bus_take  = bus_req & (bus_reg == BUS_ACK);
   wire        wr_take   = avs_write_i & (bus_reg == BUS_ACK);
   wire        wr_clear  = wr_take & (avs_address_i == lig_pkg::REG_IRQ_CLEAR);
   wire        wr_enable = wr_take & (avs_address_i == lig_pkg::REG_IRQ_ENABLE);
   wire        wr_app    = wr_take & (avs_address_i == lig_pkg::REG_APP_CTRL);
   wire [31:0] be_mask   = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                            {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire [31:0] wr_bits   = avs_writedata_i & be_mask;

   assign avs_waitrequest_o = bus_req & (bus_reg != BUS_ACK);
   assign avs_readdata_o    = rdata_reg;

   // Unmapped and write-only addresses read as zero.
   always_comb begin
      case (avs_address_i)
         lig_pkg::REG_IRQ_STATUS: rdata_next = {28'h0000000, irq_status_reg};
         lig_pkg::REG_IRQ_ENABLE: rdata_next = {28'h0000000, irq_enable_reg};
         lig_pkg::REG_STATE:      rdata_next = {13'h0000, link_status_reg, 2'h0,
                                                rb_addr_reg, color_reg, gint_reg};
         lig_pkg::REG_LEVELS:     rdata_next = {8'h00, channel3_level_reg,
                                                channel2_level_reg, channel1_level_reg};
         lig_pkg::REG_APP_CTRL:   rdata_next = {28'h0000000, app_ctrl_reg};
         default:                 rdata_next = 32'h00000000;
      endcase
   end

   // Ack lasts one cycle, separating back-to-back requests.
   always_comb begin
      case (bus_reg)
         BUS_IDLE: bus_next = bus_req ? BUS_ACK : BUS_IDLE;
         BUS_ACK:  bus_next = BUS_IDLE;
         default:  bus_next = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_reg   <= BUS_IDLE;
         rdata_reg <= 32'h00000000;
      end else begin
         bus_reg   <= bus_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts and software control
   // ----------------------------------------------------------------
   wire rb_clean = rb_done_i & ~rb_abort_i & ~link_err_i;
   wire [IRQ_W_T-1:0] irq_events = {link_err_i, master_control_frame_i,
                                    nvm_write_frame_i, rb_clean};

   // A new event wins over a clear in the same cycle.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_status_reg <= '0;
         irq_enable_reg <= '0;
         app_ctrl_reg   <= '0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~(wr_clear ? wr_bits[IRQ_W_T-1:0] : '0))
                           | irq_events;
         if (wr_enable) begin
            irq_enable_reg <= wr_bits[IRQ_W_T-1:0];
         end
         if (wr_app) begin
            app_ctrl_reg <= wr_bits[lig_pkg::APP_W-1:0];
         end
      end
   end

   assign irq_o = |(irq_status_reg & irq_enable_reg);

   // ----------------------------------------------------------------
   // Stored registers: sixteen color sets plus one extra word
   // ----------------------------------------------------------------
   wire nvm_wr_ok = nvm_write_frame_i & (nvm_wr_addr_i <= lig_pkg::NVM_ADDR_MAX);

   // Word n below 16 holds set n: channel one low, channel three high.
   genvar gi;
   generate
      for (gi = 0; gi < lig_pkg::NVM_WORDS; gi = gi + 1) begin : g_nvm
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               nvm_reg[gi] <= 24'h000000;
            end else if (nvm_wr_ok && (nvm_wr_addr_i == 6'(gi))) begin
               nvm_reg[gi] <= nvm_wr_data_i;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Readback address counter and link status
   // ----------------------------------------------------------------
   // A write reload has priority over an advance in the same cycle.
   always_comb begin
      rb_addr_next = rb_addr_reg;
      if (nvm_wr_ok) begin
         rb_addr_next = nvm_wr_addr_i;
      end else if (rb_clean) begin
         if (rb_addr_reg >= lig_pkg::NVM_ADDR_MAX) begin
            rb_addr_next = lig_pkg::NVM_ADDR_RST;
         end else begin
            rb_addr_next = rb_addr_reg + 6'h01;
         end
      end
   end

   // Errors stay until a later clean frame.
   always_comb begin
      link_status_next = link_status_reg;
      if (link_err_i) begin
         link_status_next = link_err_code_i;
      end else if (rb_clean | master_control_frame_i | direct_level_frame_i
                   | nvm_write_frame_i) begin
         link_status_next = lig_pkg::LS_OK;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rb_addr_reg     <= lig_pkg::NVM_ADDR_RST;
         link_status_reg <= lig_pkg::LS_RESET;
      end else begin
         rb_addr_reg     <= rb_addr_next;
         link_status_reg <= link_status_next;
      end
   end

   // ----------------------------------------------------------------
   // Readback response bytes and checksum
   // ----------------------------------------------------------------
   wire [1:0] app_code = app_ctrl_reg[lig_pkg::APP_PROG_ERR] ? lig_pkg::AI_PROG_ERR :
                         app_ctrl_reg[lig_pkg::APP_OVERTEMP] ? lig_pkg::AI_OVERTEMP : 2'h0;
   // Bit 1 of application info always reads low.
   wire [4:0]  application_info_field = {app_ctrl_reg[lig_pkg::APP_LOC_DEF], app_code,
                                         1'b0, app_ctrl_reg[lig_pkg::APP_TEMP_WARN]};
   wire [7:0]  b1_next = {link_status_reg, application_info_field};
   wire [7:0]  b2_next = {2'b00, 1'b0, rb_addr_reg[4:0]};
   wire [23:0] word    = nvm_reg[rb_addr_reg[4:0]];
   // Enhanced checksum: inverted carry-folded sum.
   wire [8:0]  s1 = {1'b0, rb_pid_i} + {1'b0, b1_next};
   wire [8:0]  f1 = {1'b0, s1[7:0]} + {8'h00, s1[8]};
   wire [8:0]  s2 = {1'b0, f1[7:0]} + {1'b0, b2_next};
   wire [8:0]  f2 = {1'b0, s2[7:0]} + {8'h00, s2[8]};
   wire [8:0]  s3 = {1'b0, f2[7:0]} + {1'b0, word[7:0]};
   wire [8:0]  f3 = {1'b0, s3[7:0]} + {8'h00, s3[8]};
   wire [8:0]  s4 = {1'b0, f3[7:0]} + {1'b0, word[15:8]};
   wire [8:0]  f4 = {1'b0, s4[7:0]} + {8'h00, s4[8]};
   wire [8:0]  s5 = {1'b0, f4[7:0]} + {1'b0, word[23:16]};
   wire [8:0]  f5 = {1'b0, s5[7:0]} + {8'h00, s5[8]};

   // Refreshed every cycle to track the counter.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         byte1_reg <= 8'h00;
         byte2_reg <= 8'h00;
         lo_reg    <= 8'h00;
         mid_reg   <= 8'h00;
         hi_reg    <= 8'h00;
         chk_reg   <= 8'h00;
      end else begin
         byte1_reg <= b1_next;
         byte2_reg <= b2_next;
         lo_reg    <= word[7:0];
         mid_reg   <= word[15:8];
         hi_reg    <= word[23:16];
         chk_reg   <= ~f5[7:0];
      end
   end

   assign rb_byte1_o         = byte1_reg;
   assign rb_byte2_o         = byte2_reg;
   assign stored_byte_low_o  = lo_reg;
   assign stored_byte_mid_o  = mid_reg;
   assign stored_byte_high_o = hi_reg;
   assign rb_checksum_o      = chk_reg;

   // ----------------------------------------------------------------
   // Color selection, direct levels and global intensity
   // ----------------------------------------------------------------
   wire [23:0] set_word = nvm_reg[ctrl_color_i];

   // A direct frame wins over a set reload.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         gint_reg           <= lig_pkg::GINT_RST;
         color_reg          <= lig_pkg::COLOR_RST;
         channel1_level_reg <= 8'h00;
         channel2_level_reg <= 8'h00;
         channel3_level_reg <= 8'h00;
      end else begin
         if (master_control_frame_i) begin
            gint_reg  <= ctrl_gint_i;
            color_reg <= ctrl_color_i;
         end
         if (direct_level_frame_i) begin
            channel1_level_reg <= direct_ch1_i;
            channel2_level_reg <= direct_ch2_i;
            channel3_level_reg <= direct_ch3_i;
         end else if (master_control_frame_i) begin
            channel1_level_reg <= set_word[7:0];
            channel2_level_reg <= set_word[15:8];
            channel3_level_reg <= set_word[23:16];
         end
      end
   end

   // ----------------------------------------------------------------
   // Intensity generation
   // ----------------------------------------------------------------
   wire [7:0] gscale = lig_pkg::GSCALE[gint_reg];
   wire [7:0] lvl [3];
   wire [2:0] pulses;

   assign lvl[0] = channel1_level_reg;
   assign lvl[1] = channel2_level_reg;
   assign lvl[2] = channel3_level_reg;

   // Shared phase keeps the channels aligned.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase_reg <= 15'h0000;
      end else if (phase_reg == lig_pkg::PWM_PERIOD - 15'h0001) begin
         phase_reg <= 15'h0000;
      end else begin
         phase_reg <= phase_reg + 15'h0001;
      end
   end

   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
         lig_pwm u_pwm (
            .clk_i     (clk_i),
            .sys_rst_i (sys_rst_i),
            .phase_i   (phase_reg),
            .level_i   (lvl[gi]),
            .gscale_i  (gscale),
            .pulse_o   (pulses[gi])
         );
      end
   endgenerate

   assign led_output_a_o = pulses[0];
   assign led_output_b_o = pulses[1];
   assign led_output_c_o = pulses[2];

endmodule
`default_nettype wire

// ### lig_core_chk.sv
// Concurrent checks on the top ports of the readback and intensity block.
`timescale 1ns/1ps
`default_nettype none
module lig_core_chk (
   // Clock, reset and strobes
   input wire logic        clk_i, sys_rst_i, master_control_frame_i, nvm_write_frame_i,
   input wire logic        rb_done_i, rb_abort_i, link_err_i,
   // Frame fields and response bytes
   input wire logic [5:0]  nvm_wr_addr_i,
   input wire logic [23:0] nvm_wr_data_i,
   input wire logic [2:0]  link_err_code_i,
   input wire logic [7:0]  rb_pid_i, rb_byte1_o, rb_byte2_o, rb_checksum_o,
   input wire logic [7:0]  stored_byte_low_o, stored_byte_mid_o, stored_byte_high_o,
   // LED outputs
   input wire logic        led_output_a_o, led_output_b_o, led_output_c_o
);
   // ------------
   // Helper logic
   // ------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic        seen_reg;
   logic [10:0] sum_w;
   logic [8:0]  fold_w;
   logic [7:0]  cks_w;
   logic [5:0]  nxt_w;
   logic        wr_ok_w;
   // Folded sum, inverted.
   assign sum_w   = 11'(rb_pid_i) + 11'(rb_byte1_o) + 11'(rb_byte2_o)
                  + 11'(stored_byte_low_o) + 11'(stored_byte_mid_o) + 11'(stored_byte_high_o);
   assign fold_w  = 9'(sum_w[7:0]) + 9'(sum_w[10:8]);
   assign cks_w   = ~(fold_w[7:0] + 8'(fold_w[8]));
   assign nxt_w   = (rb_byte2_o[5:0] == 6'h10) ? 6'h00 : rb_byte2_o[5:0] + 6'h01;
   assign wr_ok_w = nvm_write_frame_i && (nvm_wr_addr_i <= 6'h10);
   // Set by the first control frame.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) seen_reg <= 1'b0;
      else if (master_control_frame_i) seen_reg <= 1'b1;
   end
   rst_state_a: assert property ($fell(sys_rst_i) |=> rb_byte1_o == 8'h20 && rb_byte2_o == 8'h00)
      else $error("Bad reset state.");
   leds_dark_a: assert property (!seen_reg |-> !(led_output_a_o | led_output_b_o | led_output_c_o))
      else $error("Output lit early.");
   addr_field_a: assert property (rb_byte2_o[7:6] == 2'h0 && rb_byte2_o[5:0] <= 6'h10)
      else $error("Bad address byte.");
   info_low_a: assert property (!rb_byte1_o[1])
      else $error("Info bit one not low.");
   cnt_step_a: assert property (rb_done_i && !rb_abort_i && !link_err_i && !nvm_write_frame_i
      && !$past(rb_done_i) && !$past(nvm_write_frame_i) |-> ##2 rb_byte2_o[5:0] == $past(nxt_w, 2))
      else $error("Counter did not step.");
   cnt_hold_a: assert property (rb_done_i && (rb_abort_i || link_err_i) && !nvm_write_frame_i
      && !$past(rb_done_i) && !$past(nvm_write_frame_i) |-> ##2 $stable(rb_byte2_o) && $past($stable(rb_byte2_o)))
      else $error("Counter moved.");
   cnt_load_a: assert property (wr_ok_w |-> ##2 rb_byte2_o[5:0] == $past(nvm_wr_addr_i, 2))
      else $error("Counter not loaded.");
   data_echo_a: assert property (wr_ok_w |-> ##2 {stored_byte_high_o, stored_byte_mid_o,
      stored_byte_low_o} == $past(nvm_wr_data_i, 2)) else $error("Echo wrong.");
   link_code_a: assert property (link_err_i |-> ##2 rb_byte1_o[7:5] == $past(link_err_code_i, 2))
      else $error("Status not kept.");
   cksum_ok_a: assert property (!$past(sys_rst_i) && $stable({rb_byte1_o, rb_byte2_o,
      stored_byte_low_o, stored_byte_mid_o, stored_byte_high_o}) |-> rb_checksum_o == cks_w)
      else $error("Checksum wrong.");
   wrap_c: cover property (rb_done_i && rb_byte2_o == 8'h10);
   err_c: cover property (rb_done_i && link_err_i);
   led_c: cover property ($rose(led_output_a_o));
endmodule
bind lig_core lig_core_chk u_chk (.*);
`default_nettype wire

// ### lig_lin_master.sv
// Bus master model: sends frames, takes responses.
`timescale 1ns/1ps
`default_nettype none
module lig_lin_master #(
   parameter logic [7:0] PID = 8'h50 // Readback identifier.
) (
   // Clock and response from the slave
   input  wire logic        clk_i,
   input  wire logic [39:0] rsp_i,
   input  wire logic [7:0]  cs_i,
   // Frame strobes (control, direct level, stored write) and fields
   output var  logic [2:0]  frame_o,
   output var  logic [5:0]  addr_o,
   output var  logic [23:0] data_o,
   // Readback completion
   output var  logic [7:0]  pid_o,
   output var  logic        done_o, abort_o, err_o,
   output var  logic [2:0]  code_o
);
   // ------------
   // Frame drivers
   // ------------
   assign pid_o = PID;
   // Quiet bus at time zero.
   initial {frame_o, addr_o, data_o, done_o, abort_o, err_o, code_o} = '0;
   // Fields invert after the strobe so stale values never help.
   task automatic frame(input logic [2:0] k, input logic [5:0] a, input logic [23:0] d);
      @(posedge clk_i);
      frame_o <= k;
      addr_o <= a;
      data_o <= d;
      @(posedge clk_i);
      frame_o <= 3'h0;
      addr_o <= ~a;
      data_o <= ~d;
   endtask
   // Takes a response, checks it, then ends it.
   task automatic readback(input logic ab, er, input logic [2:0] c,
                           output logic [39:0] r, output logic ok);
      logic [10:0] s;
      @(posedge clk_i);
      @(posedge clk_i);
      r = rsp_i;
      s = 11'(PID) + 11'(r[39:32]) + 11'(r[31:24]) + 11'(r[23:16]) + 11'(r[15:8]) + 11'(r[7:0]);
      s = 11'(s[7:0]) + 11'(s[10:8]);
      s = 11'(s[7:0]) + 11'(s[8]);
      ok = (cs_i === ~s[7:0]);
      done_o <= 1'b1;
      abort_o <= ab;
      err_o <= er;
      code_o <= c;
      @(posedge clk_i);
      done_o <= 1'b0;
      abort_o <= 1'b0;
      err_o <= 1'b0;
      code_o <= ~c;
   endtask
endmodule
`default_nettype wire

// ### lig_core_tb.sv
// Self-checking bench for the readback and intensity block.
`timescale 1ns/1ps
`default_nettype none
module lig_core_tb;
   // ------------
   // Signals and model state
   // ------------
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [4:0]  avs_address_i = 5'h0;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
   logic        avs_waitrequest_o, irq_o, led_output_a_o, led_output_b_o, led_output_c_o;
   logic        rb_done_i, rb_abort_i, link_err_i, ok;
   logic [2:0]  frm, link_err_code_i;
   logic [5:0]  nvm_wr_addr_i;
   logic [23:0] nvm_wr_data_i, rnd = 24'h000061;
   logic [7:0]  rb_pid_i, rb_byte1_o, rb_byte2_o, rb_checksum_o;
   logic [7:0]  stored_byte_low_o, stored_byte_mid_o, stored_byte_high_o;
   logic [39:0] rsp;
   wire         master_control_frame_i = frm[0];
   wire         direct_level_frame_i = frm[1];
   wire         nvm_write_frame_i = frm[2];
   wire  [3:0]  ctrl_color_i = nvm_wr_data_i[3:0];
   wire  [3:0]  ctrl_gint_i = nvm_wr_data_i[7:4];
   wire  [7:0]  direct_ch1_i = nvm_wr_data_i[7:0];
   wire  [7:0]  direct_ch2_i = nvm_wr_data_i[15:8];
   wire  [7:0]  direct_ch3_i = nvm_wr_data_i[23:16];
   int          n_mismatch = 0, n_tests = 0, cyc = 0, cnt = 0, ls = 1, app = 0;
   int          na = 0, nb = 0, nc = 0;
   int          nvm [17] = '{default: 0};
   lig_core dut (.*);
   lig_lin_master lin (.clk_i(clk_i), .rsp_i({rb_byte1_o, rb_byte2_o, stored_byte_low_o,
      stored_byte_mid_o, stored_byte_high_o}), .cs_i(rb_checksum_o), .frame_o(frm),
      .addr_o(nvm_wr_addr_i), .data_o(nvm_wr_data_i), .pid_o(rb_pid_i), .done_o(rb_done_i),
      .abort_o(rb_abort_i), .err_o(link_err_i), .code_o(link_err_code_i));
   // 8 ns clock and a cycle ceiling.
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         end_sim();
      end
   end
   function automatic logic [23:0] lfsr(input logic [23:0] v);
      return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
   endfunction
   // Expected first byte.
   function automatic logic [7:0] byte1_f();
      return {ls[2:0], app[3], app[2] ? 2'h3 : (app[1] ? 2'h2 : 2'h0), 1'b0, app[0]};
   endfunction
   task automatic chk_rsp(input logic [40:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t response %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   // Request stands until waitrequest is low.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_writedata_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   // Readback, then model update.
   task automatic rb(input logic ab, er, input logic [2:0] c);
      lin.readback(ab, er, c, rsp, ok);
      chk_rsp({ok, rsp}, {1'b1, byte1_f(), 2'h0, cnt[5:0], nvm[cnt][7:0],
               nvm[cnt][15:8], nvm[cnt][23:16]});
      if (er) ls = c;
      else if (!ab) begin
         ls = 0;
         cnt = (cnt == 16) ? 0 : cnt + 1;
      end
   endtask
   task automatic end_sim();
      $display("Tests %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rb(1'b0, 1'b0, 3'h0);
      for (int i = 0; i <= 16; i++) begin
         rnd = lfsr(rnd);
         nvm[i] = int'(rnd);
         lin.frame(3'h4, 6'(i), rnd);
         cnt = i;
      end
      lin.frame(3'h4, 6'h11, ~rnd);
      for (int i = 0; i < 19; i++) rb(1'b0, 1'b0, 3'h0);
      rb(1'b1, 1'b0, 3'h0);
      for (int c = 4; c < 8; c++) rb(1'b0, 1'b1, 3'(c));
      rb(1'b0, 1'b0, 3'h0);
      for (int a = 0; a < 16; a++) begin
         app = a;
         bus(1'b1, lig_pkg::REG_APP_CTRL, 32'(a));
         rb(1'b0, 1'b0, 3'h0);
      end
      bus(1'b0, lig_pkg::REG_APP_CTRL, 32'h0);
      chk_reg(q, 32'hf);
      for (int i = 0; i < 16; i++) begin
         lin.frame(3'h1, 6'h0, {16'h0, 4'(i), 4'(i)});
         bus(1'b0, lig_pkg::REG_LEVELS, 32'h0);
         chk_reg(q, 32'(nvm[i]));
         bus(1'b0, lig_pkg::REG_STATE, 32'h0);
         chk_reg(q, {13'h0, ls[2:0], 2'h0, cnt[5:0], 4'(i), 4'(i)});
      end
      lin.frame(3'h1, 6'h0, 24'h0000b0);
      lin.frame(3'h2, 6'h0, 24'h0033e6);
      bus(1'b0, lig_pkg::REG_LEVELS, 32'h0);
      chk_reg(q, 32'h0033e6);
      repeat (32640) @(posedge clk_i);
      repeat (32640) begin
         @(posedge clk_i);
         na += int'(led_output_a_o === 1'b1);
         nb += int'(led_output_b_o === 1'b1);
         nc += int'(led_output_c_o === 1'b1);
      end
      // Code 0xb is factor 64 of 128.
      chk_reg(32'(na), 32'(230 * 64));
      chk_reg(32'(nb), 32'(51 * 64));
      chk_reg(32'(nc), 32'h0);
      bus(1'b0, lig_pkg::REG_IRQ_ENABLE, 32'h0);
      chk_reg(q, 32'h0);
      bus(1'b0, lig_pkg::REG_IRQ_STATUS, 32'h0);
      chk_reg({q[31:1], irq_o}, 32'he);
      bus(1'b1, lig_pkg::REG_IRQ_ENABLE, 32'h4);
      bus(1'b1, lig_pkg::REG_IRQ_STATUS, 32'h0);
      bus(1'b0, lig_pkg::REG_IRQ_STATUS, 32'h0);
      chk_reg({irq_o, q[30:0]}, 32'h8000000f);
      bus(1'b1, lig_pkg::REG_IRQ_CLEAR, 32'h4);
      bus(1'b0, lig_pkg::REG_IRQ_STATUS, 32'h0);
      chk_reg({irq_o, q[30:0]}, 32'h0000000b);
      bus(1'b1, 5'h1c, 32'hffffffff);
      bus(1'b0, 5'h1c, 32'h0);
      chk_reg(q, 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
